// ### sdr_defs.svh
// Purpose: Constants for the SDRAM row activate and read burst link
// Assumes: 20 MHz clock, 50 ns period, four banks, x32 data
// Notes: Times in ns, cycle counts derived by rounding up
`ifndef SDR_DEFS_SVH
`define SDR_DEFS_SVH
`define SDR_CLK_PERIOD_NS 50
`define SDR_ACT_TO_RW_NS 20
`define SDR_ACT_TO_ACT_SAME_NS 70
`define SDR_ACT_TO_ACT_OTHER_NS 14
`define SDR_PRECHARGE_NS 20
`define SDR_CYC(ns) (((ns) + `SDR_CLK_PERIOD_NS - 1) / `SDR_CLK_PERIOD_NS)
`define SDR_ACT_TO_RW_CYC `SDR_CYC(`SDR_ACT_TO_RW_NS)
`define SDR_ACT_TO_ACT_SAME_CYC `SDR_CYC(`SDR_ACT_TO_ACT_SAME_NS)
`define SDR_ACT_TO_ACT_OTHER_CYC `SDR_CYC(`SDR_ACT_TO_ACT_OTHER_NS)
`define SDR_PRECHARGE_CYC `SDR_CYC(`SDR_PRECHARGE_NS)
`define SDR_READ_LATENCY 3
`define SDR_BURST_LEN 4
`define SDR_FULL_PAGE 1'b0
`define SDR_COL_W 8
`define SDR_ROW_W 12
`define SDR_BANKS 4
`define SDR_DATA_W 32
`define SDR_CNT_W 4
`define SDR_AP_BIT 10
`define SDR_COL_LAST 8'hFF
`define SDR_COL_ZERO 8'h00
`endif

// ### sdr_pkg.sv
`include "sdr_defs.svh"
package sdr_pkg;
	typedef enum logic [2:0] {SDR_NOP, SDR_ACT, SDR_RD, SDR_WR, SDR_PRE, SDR_BST} sdr_cmd_e;
	typedef logic [`SDR_CNT_W-1:0] sdr_cnt_t;
endpackage

// ### sdr_link_if.sv
`timescale 1ns/100ps
`include "sdr_defs.svh"
interface sdr_link_if (input wire logic clk);
	import sdr_pkg::*;
	sdr_cmd_e cmd;
	logic [1:0] bank;
	logic [`SDR_ROW_W-1:0] addr;
	logic byte_mask_input;
	logic [`SDR_DATA_W-1:0] dq_out;
	logic dq_oe;
	modport device (input cmd, input bank, input addr, input byte_mask_input,
		output dq_out, output dq_oe);
	modport ctrl (output cmd, output bank, output addr, output byte_mask_input,
		input dq_out, input dq_oe);
endinterface

// ### sdr_device.sv
// Purpose: SDRAM end: row state, read burst pipeline, output masking
// Assumes: Commands legal per the controller's own spacing
// Notes: Storage returns a column-derived pattern; writes handled elsewhere

`timescale 1ns/100ps
`include "sdr_defs.svh"
module sdr_device
	import sdr_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	sdr_link_if.device link,
	output logic [`SDR_BANKS-1:0] row_open,
	output logic burst_busy
);
	// Row state seen from one bank
	typedef enum logic [1:0] {SDR_BK_IDLE, SDR_BK_ACTIVE, SDR_BK_AUTO} sdr_bk_st_e;

	wire [`SDR_BANKS-1:0] next_row_open;
	logic rd_act;
	logic rd_ap;
	logic [1:0] rd_bank;
	logic [`SDR_COL_W-1:0] rd_col;
	sdr_cnt_t rd_left;
	logic [`SDR_READ_LATENCY-1:0] pipe_v;
	logic [`SDR_COL_W-1:0] pipe_c [`SDR_READ_LATENCY];
	// Two-stage mask delay; stage 0 also qualifies a write
	logic [1:0] mask_d;
	logic wr_kill;

	// Bank match written once as a function; every bank and the cut test call it
	function automatic logic to_bank(input sdr_cmd_e c, input sdr_cmd_e want,
		input logic [1:0] cb, input logic [1:0] b);
		return c == want && cb == b;
	endfunction

	wire is_rd = link.cmd == SDR_RD;
	// Write, terminate or precharge of the reading bank stops new beats
	wire is_cut = link.cmd == SDR_WR || link.cmd == SDR_BST
		|| to_bank(link.cmd, SDR_PRE, link.bank, rd_bank);
	wire issue = is_rd || (rd_act && !is_cut);
	wire [`SDR_COL_W-1:0] issue_col = is_rd ? link.addr[`SDR_COL_W-1:0] : rd_col;
	wire last_beat = !`SDR_FULL_PAGE && rd_left == sdr_cnt_t'(1);
	wire burst_done = rd_act && !is_rd && !is_cut && last_beat;
	wire [`SDR_COL_W-1:0] col_inc = (issue_col == `SDR_COL_LAST) ? `SDR_COL_ZERO
		: issue_col + `SDR_COL_W'(1);
	// Auto precharge flag rides on the address bus with a read
	wire ap_new = link.addr[`SDR_AP_BIT];

	// Per-bank row state; auto precharge waits for the burst to finish
	genvar k;
	generate
		for (k = 0; k < `SDR_BANKS; k++)
		begin : g_bank
			sdr_bk_st_e st;
			sdr_bk_st_e next_st;
			wire act_k = to_bank(link.cmd, SDR_ACT, link.bank, 2'(k));
			wire pre_k = to_bank(link.cmd, SDR_PRE, link.bank, 2'(k));
			wire rd_ap_k = to_bank(link.cmd, SDR_RD, link.bank, 2'(k)) && ap_new;
			wire done_k = burst_done && rd_ap && rd_bank == 2'(k);

			always_comb
			begin
				next_st = st;
				case (st)
					SDR_BK_IDLE:
						if (act_k)
							next_st = SDR_BK_ACTIVE;
					SDR_BK_ACTIVE:
						if (pre_k)
							next_st = SDR_BK_IDLE;
						else if (rd_ap_k)
							next_st = SDR_BK_AUTO;
					SDR_BK_AUTO:
						if (pre_k || done_k)
							next_st = SDR_BK_IDLE;
						else if ((is_rd && !rd_ap_k) || is_cut)
							next_st = SDR_BK_ACTIVE;
					default:
						next_st = SDR_BK_IDLE;
				endcase
			end

			always_ff @(posedge clk)
			begin
				if (srst)
					st <= SDR_BK_IDLE;
				else
					st <= next_st;
			end

			assign next_row_open[k] = next_st != SDR_BK_IDLE;
		end
	endgenerate

	// Registered copy of the bank states for the outside
	always_ff @(posedge clk)
	begin
		if (srst)
			row_open <= '0;
		else
			row_open <= next_row_open;
	end

	// Burst column counter; a new read restarts it gaplessly
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rd_act <= 1'b0;
			rd_left <= '0;
			rd_bank <= '0;
			rd_ap <= 1'b0;
			rd_col <= '0;
		end
		else if (is_rd)
		begin
			rd_act <= !last_beat || `SDR_BURST_LEN > 1;
			rd_left <= sdr_cnt_t'(`SDR_BURST_LEN - 1);
			rd_bank <= link.bank;
			rd_ap <= link.addr[`SDR_AP_BIT];
			rd_col <= col_inc;
		end
		else if (is_cut || burst_done)
			rd_act <= 1'b0;
		else if (rd_act)
		begin
			rd_left <= rd_left - sdr_cnt_t'(1);
			rd_col <= col_inc;
		end
	end

	// Latency pipeline: one stage per clock of read latency
	always_ff @(posedge clk)
	begin
		if (srst)
			pipe_v <= '0;
		else
			pipe_v <= {pipe_v[`SDR_READ_LATENCY-2:0], issue};
	end

	// Column pipeline has no reset; only the valid bits need one
	genvar g;
	generate
		for (g = 0; g < `SDR_READ_LATENCY; g++)
		begin : g_pipe
			if (g == 0)
			begin : g_first
				always_ff @(posedge clk)
					pipe_c[g] <= issue_col;
			end
			else
			begin : g_rest
				always_ff @(posedge clk)
					pipe_c[g] <= pipe_c[g-1];
			end
		end
	endgenerate

	// Mask reaches the drivers two clocks late
	always_ff @(posedge clk)
	begin
		if (srst)
			mask_d <= '0;
		else
			mask_d <= {mask_d[0], link.byte_mask_input};
	end

	// A write after a masked clock kills the tail outright
	always_ff @(posedge clk)
	begin
		if (srst)
			wr_kill <= 1'b0;
		else if (is_rd)
			wr_kill <= 1'b0;
		else if (link.cmd == SDR_WR && mask_d[0])
			wr_kill <= 1'b1;
		else if (!(|pipe_v))
			wr_kill <= 1'b0;
	end

	wire drive = pipe_v[`SDR_READ_LATENCY-1] && !mask_d[1] && !wr_kill;
	always_ff @(posedge clk)
	begin
		if (srst)
			link.dq_oe <= 1'b0;
		else
			link.dq_oe <= drive;
	end

	// Data lines follow the column pipeline every clock, whether the enable is high or low
	always_ff @(posedge clk)
	begin
		if (srst)
			link.dq_out <= '0;
		else
			link.dq_out <= {`SDR_DATA_W/`SDR_COL_W{pipe_c[`SDR_READ_LATENCY-1]}};
	end

	// Busy spans issue through the last pipeline stage
	always_ff @(posedge clk)
	begin
		if (srst)
			burst_busy <= 1'b0;
		else
			burst_busy <= issue || (|pipe_v);
	end
endmodule

// ### sdr_ctrl.sv
// Purpose: Controller end: one request at a time, bank spacing kept per bank, activate-to-read wait shared by all banks
// Assumes: User holds req until ack
// Notes: Only row activate, precharge and reads with optional auto precharge
`timescale 1ns/100ps
`include "sdr_defs.svh"
module sdr_ctrl
	import sdr_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	sdr_link_if.ctrl link,
	input wire logic req,
	input wire logic [1:0] req_bank,
	input wire logic [`SDR_ROW_W-1:0] req_row,
	input wire logic [`SDR_COL_W-1:0] req_col,
	input wire logic req_ap,
	output logic ack,
	output logic [`SDR_DATA_W-1:0] rd_data,
	output logic rd_valid
);
	typedef enum logic [1:0] {SDR_IDLE, SDR_OPEN, SDR_READ} sdr_st_e;
	sdr_st_e st;
	logic [`SDR_BANKS-1:0] open_b;
	logic [`SDR_ROW_W-1:0] open_row [`SDR_BANKS];
	sdr_cnt_t bank_wait [`SDR_BANKS];
	sdr_cnt_t rcd_wait;
	sdr_cnt_t rrd_wait;
	sdr_cnt_t burst_wait;
	wire hit = open_b[req_bank] && open_row[req_bank] == req_row;
	wire bank_ok = bank_wait[req_bank] == '0;
	wire do_pre = req && st == SDR_IDLE && open_b[req_bank] && !hit && bank_ok;
	wire do_act = req && st == SDR_IDLE && !open_b[req_bank] && bank_ok && rrd_wait == '0;
	wire do_rd = req && st == SDR_IDLE && hit && rcd_wait == '0 && burst_wait == '0;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st <= SDR_IDLE;
			open_b <= '0;
			rcd_wait <= '0;
			rrd_wait <= '0;
			burst_wait <= '0;
			ack <= 1'b0;
			link.cmd <= SDR_NOP;
			link.bank <= '0;
			link.addr <= '0;
			link.byte_mask_input <= 1'b0;
		end
		else
		begin
			ack <= do_rd;
			link.cmd <= do_pre ? SDR_PRE : do_act ? SDR_ACT : do_rd ? SDR_RD : SDR_NOP;
			link.bank <= req_bank;
			link.addr <= do_act ? req_row
				: {{`SDR_ROW_W-`SDR_COL_W{1'b0}}, req_col} | (`SDR_ROW_W'(req_ap) << `SDR_AP_BIT);
			if (rcd_wait != '0)
				rcd_wait <= rcd_wait - sdr_cnt_t'(1);
			if (rrd_wait != '0)
				rrd_wait <= rrd_wait - sdr_cnt_t'(1);
			// Next read waits for the whole burst; no wanted word is cut
			if (burst_wait != '0)
				burst_wait <= burst_wait - sdr_cnt_t'(1);
			if (do_rd)
				burst_wait <= sdr_cnt_t'(`SDR_BURST_LEN - 1);
			if (do_act)
			begin
				open_b[req_bank] <= 1'b1;
				open_row[req_bank] <= req_row;
				rcd_wait <= sdr_cnt_t'(`SDR_ACT_TO_RW_CYC - 1);
				rrd_wait <= sdr_cnt_t'(`SDR_ACT_TO_ACT_OTHER_CYC - 1);
			end
			if (do_pre || (do_rd && req_ap))
				open_b[req_bank] <= 1'b0;
			st <= do_rd ? SDR_READ : SDR_IDLE;
		end
	end
	// Per-bank spacing; covers precharge and same-bank activate gaps
	generate
		for (genvar i = 0; i < `SDR_BANKS; i++)
		begin : g_bank
			always_ff @(posedge clk)
			begin
				if (srst)
					bank_wait[i] <= '0;
				else if (req_bank == 2'(i) && do_act)
					bank_wait[i] <= sdr_cnt_t'(`SDR_ACT_TO_ACT_SAME_CYC - 1);
				else if (req_bank == 2'(i) && (do_pre || (do_rd && req_ap)))
					bank_wait[i] <= sdr_cnt_t'(`SDR_PRECHARGE_CYC + `SDR_BURST_LEN);
				else if (req_bank == 2'(i) && do_rd)
					bank_wait[i] <= sdr_cnt_t'(`SDR_BURST_LEN - 1);
				else if (bank_wait[i] != '0)
					bank_wait[i] <= bank_wait[i] - sdr_cnt_t'(1);
			end
		end
	endgenerate
	// Read data taken from the pins; no writes issued, so no turnaround
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end
		else
		begin
			rd_valid <= link.dq_oe;
			rd_data <= link.dq_out;
		end
	end
endmodule

// ### sdr_link_checker.sv
// Purpose: Assertions on the controller to device link
// Assumes: Byte mask held low, fixed bursts of four
// Notes: Watches link signals only
`timescale 1ns/100ps
`include "sdr_defs.svh"
module sdr_link_checker
	import sdr_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input sdr_cmd_e cmd,
	input wire logic [1:0] bank,
	input wire logic [`SDR_ROW_W-1:0] addr,
	input wire logic [`SDR_DATA_W-1:0] dq_out,
	input wire logic dq_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Rows seen opened on the link; auto precharge closes at the read
	logic [`SDR_BANKS-1:0] seen_open;
	always_ff @(posedge clk)
	begin
		if (srst)
			seen_open <= '0;
		else if (cmd == SDR_ACT)
			seen_open[bank] <= 1'b1;
		else if (cmd == SDR_PRE || (cmd == SDR_RD && addr[`SDR_AP_BIT]))
			seen_open[bank] <= 1'b0;
	end
	property p_act_first;
		cmd == SDR_RD |-> seen_open[bank];
	endproperty
	a_act_first: assert property (p_act_first) else $error("read without activate");
	property p_same_act;
		cmd == SDR_ACT |=> !(cmd == SDR_ACT && bank == $past(bank));
	endproperty
	a_same_act: assert property (p_same_act) else $error("same bank activates too close");
	property p_latency;
		cmd == SDR_RD |-> ##4 dq_oe;
	endproperty
	a_latency: assert property (p_latency) else $error("read data late");
	property p_first_word;
		cmd == SDR_RD |-> ##4 dq_out == {4{$past(addr[7:0], 4)}};
	endproperty
	a_first_word: assert property (p_first_word) else $error("first word wrong");
	property p_cause;
		$rose(dq_oe) |-> $past(cmd, 4) == SDR_RD;
	endproperty
	a_cause: assert property (p_cause) else $error("output without read");
	property p_length;
		cmd == SDR_RD ##1 (cmd == SDR_NOP)[*4] |-> dq_oe[*4];
	endproperty
	a_length: assert property (p_length) else $error("burst cut short");
	property p_release;
		cmd == SDR_RD ##1 (cmd == SDR_NOP)[*7] |-> ##1 !dq_oe;
	endproperty
	a_release: assert property (p_release) else $error("pins not released");
	property p_step;
		dq_oe && $past(dq_oe) && $past(cmd, 4) != SDR_RD |->
			dq_out[7:0] == $past(dq_out[7:0]) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("column step wrong");
	c_ap: cover property (cmd == SDR_RD && addr[`SDR_AP_BIT]);
	c_pre: cover property (cmd == SDR_PRE);
	c_gapless: cover property (dq_oe && $past(cmd, 4) == SDR_RD && $past(dq_oe));
endmodule

// ### sdr_row_activate_read_burst_tb.sv
// Purpose: Self-checking bench for controller and device together
// Assumes: Data word is its column replicated
// Notes: Requests held until ack is sampled high at a rising edge
`timescale 1ns/100ps
`include "sdr_defs.svh"
module sdr_row_activate_read_burst_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic req = 1'b0;
	logic [1:0] req_bank = 2'h0;
	logic [`SDR_ROW_W-1:0] req_row = 12'h000;
	logic [`SDR_COL_W-1:0] req_col = 8'h00;
	logic req_ap = 1'b0;
	logic ack;
	logic [`SDR_DATA_W-1:0] rd_data;
	logic rd_valid;
	logic [`SDR_BANKS-1:0] row_open;
	logic burst_busy;
	logic [31:0] exp_q[$];
	logic [31:0] e;
	int bad_count = 0;
	int checks = 0;
	int i;
	sdr_link_if u_sdr_link_if (.clk(clk));
	sdr_ctrl u_sdr_ctrl (.clk(clk), .srst(srst), .link(u_sdr_link_if), .req(req),
		.req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_ap(req_ap),
		.ack(ack), .rd_data(rd_data), .rd_valid(rd_valid));
	sdr_device u_sdr_device (.clk(clk), .srst(srst), .link(u_sdr_link_if),
		.row_open(row_open), .burst_busy(burst_busy));
	sdr_link_checker u_sdr_link_checker (.clk(clk), .srst(srst), .cmd(u_sdr_link_if.cmd),
		.bank(u_sdr_link_if.bank), .addr(u_sdr_link_if.addr),
		.dq_out(u_sdr_link_if.dq_out), .dq_oe(u_sdr_link_if.dq_oe));
	initial
	begin
		forever #25 clk = ~clk;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task rd_req(input logic [1:0] b, input logic [11:0] r, input logic [7:0] c, input logic ap);
		int n;
		@(posedge clk);
		req <= 1'b1;
		req_bank <= b;
		req_row <= r;
		req_col <= c;
		req_ap <= ap;
		for (n = 0; n < 4; n++)
			exp_q.push_back({4{c + n[7:0]}});
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 60);
		req <= 1'b0;
		if (n >= 60)
		begin
			bad_count++;
			give_verdict();
		end
	endtask
	task drain;
		int n;
		n = 0;
		while ((exp_q.size() > 0 || burst_busy !== 1'b0) && n < 60)
		begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		if (n >= 60)
		begin
			bad_count++;
			give_verdict();
		end
	endtask
	always @(posedge clk)
		if (rd_valid === 1'b1)
		begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data;
			chk(rd_data, e);
		end
	initial
	begin
		void'($urandom(32'h769b));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		rd_req(2'h0, 12'h005, 8'h10, 1'b0);
		drain();
		chk({31'h0, row_open[0]}, 32'h1);
		$display("test open row read done");
		rd_req(2'h0, 12'hABC, 8'hFE, 1'b1);
		drain();
		chk({31'h0, row_open[0]}, 32'h0);
		$display("test wrap with auto precharge done");
		for (i = 0; i < 12; i++)
			rd_req(i[1:0], 12'($urandom), 8'($urandom), 1'($urandom));
		drain();
		chk(exp_q.size(), 32'h0);
		$display("test back to back random reads done");
		give_verdict();
	end
endmodule
